// File: tdf_regs.vh
`ifndef TDF_REGS_VH
`define TDF_REGS_VH
// frame layout
`define TDF_FRAME_LEN 7'd107
`define TDF_LAST_BYTE 7'd106
`define TDF_RAW_FIRST 7'd6
`define TDF_RAW_LAST 7'd25
`define TDF_BASE_FIRST 7'd40
`define TDF_BASE_LAST 7'd59
`define TDF_DIFF_FIRST 7'd74
`define TDF_DIFF_LAST 7'd93
// fixed bytes
`define TDF_HDR0 8'h0d
`define TDF_HDR1 8'h0a
`define TDF_HDR2 8'h80
`define TDF_TAG1 8'h01
`define TDF_TAG2 8'h02
`define TDF_ZERO 8'h00
`define TDF_TRAIL 8'hff
// serial timing
`define TDF_CLK_HZ 20000000
`define TDF_BAUD 115200
`define TDF_BIT_CYC ((`TDF_CLK_HZ + `TDF_BAUD / 2) / `TDF_BAUD)
`define TDF_CHAR_BITS 4'd10
`endif

// File: tdf_uart_tx.v
`timescale 1ns/10ps
`default_nettype none
`include "tdf_regs.vh"
module tdf_uart_tx #(
    parameter BIT_CYC = `TDF_BIT_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire [7:0] data,
    output reg busy_ff,
    output reg txd_ff
);
    reg [15:0] cnt_ff;
    reg [3:0] bit_ff;
    reg [8:0] shf_ff;
    // ************************************
    // start, eight data lsb first, stop
    // ************************************
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy_ff <= 1'b0;
            txd_ff <= 1'b1;
            cnt_ff <= 16'h0000;
            bit_ff <= 4'h0;
            shf_ff <= 9'h1ff;
        end
        else if (!busy_ff)
        begin
            if (start)
            begin
                busy_ff <= 1'b1;
                txd_ff <= 1'b0;
                shf_ff <= {1'b1, data};
                cnt_ff <= 16'h0000;
                bit_ff <= 4'h0;
            end
        end
        else if (cnt_ff == BIT_CYC[15:0] - 16'h0001)
        begin
            cnt_ff <= 16'h0000;
            if (bit_ff == `TDF_CHAR_BITS - 4'h1)
            begin
                busy_ff <= 1'b0;
                txd_ff <= 1'b1;
            end
            else
            begin
                bit_ff <= bit_ff + 4'h1;
                txd_ff <= shf_ff[0];
                shf_ff <= {1'b1, shf_ff[8:1]};
            end
        end
        else
        begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
endmodule // tdf_uart_tx
`default_nettype wire

// File: tdf_frame_tx.v
// Notes on behaviour
// - header 0d, 0a, 80, firmware revision
// - bytes 4-5 caps, 6-25 raw counts
// - bytes 26-33 caps, snr, supply mask
// - bytes 34-39 status; 40-59 baselines
// - status low inputs 0-7, high 8-9
// - bytes 60-69 caps, snr, ground mask
// - byte 70 dac, outputs, difference counts
// - bytes 94-103 caps, snr, checks, masks
// - trailer 00 ff ff, 107 bytes
// - masks come from self-test results
// - mask inputs 0-7 low, 8-9 high
// - rail short bit set when shorted
// - modulator check 0 ok,1 high,2 low
// - pin pair short bit when shorted
// - high capacitance bit above 40 pF
// - frames sent at 115200 baud when enabled
`timescale 1ns/10ps
`default_nettype none
`include "tdf_regs.vh"
module tdf_frame_tx #(
    parameter BIT_CYC = `TDF_BIT_CYC
) (
    // clock and reset
    input wire SYS_CLK,
    input wire RESET_N,
    // control
    input wire DEBUG_ENABLE,
    input wire FRAME_REQUEST,
    // scan values, input n at bits of index n
    input wire [79:0] INPUT_PARASITIC_CAP,
    input wire [159:0] INPUT_RAW_COUNT,
    input wire [159:0] INPUT_BASELINE_COUNT,
    input wire [159:0] INPUT_DIFFERENCE_COUNT,
    input wire [39:0] INPUT_PAIR_SNR,
    input wire [9:0] SENSE_INPUT_STATUS,
    input wire [9:0] GENERAL_OUTPUT_STATUS,
    input wire [7:0] COMPENSATED_CURRENT_DAC,
    input wire [7:0] FIRMWARE_REVISION_BYTE,
    // power-on self-test results
    input wire [9:0] SUPPLY_SHORT_MASK,
    input wire [9:0] GROUND_SHORT_MASK,
    input wire [9:0] PIN_PAIR_SHORT_MASK,
    input wire [9:0] HIGH_CAPACITANCE_MASK,
    input wire [1:0] MODULATOR_CAP_CHECK,
    // serial out and status
    output reg DELAY_PIN_TXD,
    output reg FRAME_BUSY
);
    reg [79:0] cap_ff;
    reg [159:0] raw_ff;
    reg [159:0] base_ff;
    reg [159:0] diff_ff;
    reg [39:0] snr_ff;
    reg [9:0] stat_ff;
    reg [9:0] gpo_ff;
    reg [7:0] dac_ff;
    reg [7:0] rev_ff;
    reg [9:0] vdd_ff;
    reg [9:0] gnd_ff;
    reg [9:0] p2p_ff;
    reg [9:0] cph_ff;
    reg [1:0] cmod_ff;
    reg [6:0] idx_ff;
    reg active_ff;
    reg launch_ff;
    reg [7:0] byte_ff;
    reg [7:0] nxt_byte;
    reg [6:0] off;
    wire tx_busy;
    wire tx_line;
    // ************************************
    // byte mux
    // ************************************
    always @*
    begin
        nxt_byte = `TDF_ZERO;
        off = 7'd0;
        if (idx_ff >= `TDF_RAW_FIRST && idx_ff <= `TDF_RAW_LAST)
        begin
            off = idx_ff - `TDF_RAW_FIRST;
            nxt_byte = off[0] ? raw_ff[off[6:1]*16 +: 8]
                : raw_ff[off[6:1]*16+8 +: 8];
        end
        else if (idx_ff >= `TDF_BASE_FIRST && idx_ff <= `TDF_BASE_LAST)
        begin
            off = idx_ff - `TDF_BASE_FIRST;
            nxt_byte = off[0] ? base_ff[off[6:1]*16 +: 8]
                : base_ff[off[6:1]*16+8 +: 8];
        end
        else if (idx_ff >= `TDF_DIFF_FIRST && idx_ff <= `TDF_DIFF_LAST)
        begin
            off = idx_ff - `TDF_DIFF_FIRST;
            nxt_byte = off[0] ? diff_ff[off[6:1]*16 +: 8]
                : diff_ff[off[6:1]*16+8 +: 8];
        end
        else
        begin
            case (idx_ff)
                7'd0: nxt_byte = `TDF_HDR0;
                7'd1: nxt_byte = `TDF_HDR1;
                7'd2: nxt_byte = `TDF_HDR2;
                7'd3: nxt_byte = rev_ff;
                7'd4: nxt_byte = cap_ff[7:0];
                7'd5: nxt_byte = cap_ff[15:8];
                7'd26: nxt_byte = cap_ff[23:16];
                7'd27: nxt_byte = cap_ff[31:24];
                7'd29: nxt_byte = snr_ff[7:0];
                7'd31: nxt_byte = snr_ff[15:8];
                7'd32: nxt_byte = {6'h00, vdd_ff[9:8]};
                7'd33: nxt_byte = vdd_ff[7:0];
                7'd35: nxt_byte = `TDF_TAG1;
                7'd37: nxt_byte = {6'h00, stat_ff[9:8]};
                7'd39: nxt_byte = stat_ff[7:0];
                7'd60: nxt_byte = cap_ff[39:32];
                7'd61: nxt_byte = cap_ff[47:40];
                7'd62: nxt_byte = cap_ff[55:48];
                7'd63: nxt_byte = snr_ff[23:16];
                7'd65: nxt_byte = snr_ff[31:24];
                7'd66: nxt_byte = {6'h00, gnd_ff[9:8]};
                7'd67: nxt_byte = gnd_ff[7:0];
                7'd69: nxt_byte = `TDF_TAG2;
                7'd70: nxt_byte = dac_ff;
                7'd71: nxt_byte = {6'h00, gpo_ff[9:8]};
                7'd73: nxt_byte = gpo_ff[7:0];
                7'd94: nxt_byte = cap_ff[63:56];
                7'd95: nxt_byte = cap_ff[71:64];
                7'd96: nxt_byte = cap_ff[79:72];
                7'd97: nxt_byte = snr_ff[39:32];
                7'd99: nxt_byte = {6'h00, cmod_ff};
                7'd100: nxt_byte = {6'h00, p2p_ff[9:8]};
                7'd101: nxt_byte = p2p_ff[7:0];
                7'd102: nxt_byte = {6'h00, cph_ff[9:8]};
                7'd103: nxt_byte = cph_ff[7:0];
                7'd105: nxt_byte = `TDF_TRAIL;
                7'd106: nxt_byte = `TDF_TRAIL;
                default: nxt_byte = `TDF_ZERO;
            endcase
        end
    end
    // ************************************
    // frame sequencer
    // ************************************
    // launch waits one cycle so the uart busy flag is seen settled
    always @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            active_ff <= 1'b0;
            launch_ff <= 1'b0;
            idx_ff <= 7'd0;
            byte_ff <= 8'h00;
            FRAME_BUSY <= 1'b0;
            DELAY_PIN_TXD <= 1'b1;
            cap_ff <= 80'h0;
            raw_ff <= 160'h0;
            base_ff <= 160'h0;
            diff_ff <= 160'h0;
            snr_ff <= 40'h0;
            stat_ff <= 10'h000;
            gpo_ff <= 10'h000;
            dac_ff <= 8'h00;
            rev_ff <= 8'h00;
            vdd_ff <= 10'h000;
            gnd_ff <= 10'h000;
            p2p_ff <= 10'h000;
            cph_ff <= 10'h000;
            cmod_ff <= 2'h0;
        end
        else
        begin
            DELAY_PIN_TXD <= tx_line;
            launch_ff <= 1'b0;
            if (!active_ff)
            begin
                if (DEBUG_ENABLE && FRAME_REQUEST)
                begin
                    cap_ff <= INPUT_PARASITIC_CAP;
                    raw_ff <= INPUT_RAW_COUNT;
                    base_ff <= INPUT_BASELINE_COUNT;
                    diff_ff <= INPUT_DIFFERENCE_COUNT;
                    snr_ff <= INPUT_PAIR_SNR;
                    stat_ff <= SENSE_INPUT_STATUS;
                    gpo_ff <= GENERAL_OUTPUT_STATUS;
                    dac_ff <= COMPENSATED_CURRENT_DAC;
                    rev_ff <= FIRMWARE_REVISION_BYTE;
                    vdd_ff <= SUPPLY_SHORT_MASK;
                    gnd_ff <= GROUND_SHORT_MASK;
                    p2p_ff <= PIN_PAIR_SHORT_MASK;
                    cph_ff <= HIGH_CAPACITANCE_MASK;
                    cmod_ff <= MODULATOR_CAP_CHECK;
                    idx_ff <= 7'd0;
                    active_ff <= 1'b1;
                    FRAME_BUSY <= 1'b1;
                end
            end
            else if (!tx_busy && !launch_ff)
            begin
                byte_ff <= nxt_byte;
                launch_ff <= 1'b1;
                if (idx_ff == `TDF_LAST_BYTE)
                begin
                    active_ff <= 1'b0;
                end
                else
                begin
                    idx_ff <= idx_ff + 7'd1;
                end
            end
            if (!active_ff && !tx_busy && !launch_ff && FRAME_BUSY
                && !(DEBUG_ENABLE && FRAME_REQUEST))
            begin
                FRAME_BUSY <= 1'b0;
            end
        end
    end
    tdf_uart_tx #(
        .BIT_CYC(BIT_CYC)
    ) u_tx (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .start(launch_ff),
        .data(byte_ff),
        .busy_ff(tx_busy),
        .txd_ff(tx_line)
    );
endmodule // tdf_frame_tx
`default_nettype wire

// File: tdf_frame_tx_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// port checks on the frame sender
// ***
module tdf_frame_tx_chk #(
    parameter BIT_CYC = 174
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // control
    input wire logic DEBUG_ENABLE,
    input wire logic FRAME_REQUEST,
    // serial out and status
    input wire logic DELAY_PIN_TXD,
    input wire logic FRAME_BUSY
);
    logic [15:0] run_ff;
    logic [15:0] gap_ff;
    logic [31:0] len_ff;
    logic [7:0] chr_ff;
    logic last_ff;
    wire take = DEBUG_ENABLE && FRAME_REQUEST;
    // data bits fall too: a fall is a start bit only after the data cells
    wire start_seen = last_ff && !DELAY_PIN_TXD && gap_ff >= 9 * BIT_CYC;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // run length of the line level, frame length, start bits
    always @(posedge SYS_CLK)
    begin
        last_ff <= DELAY_PIN_TXD;
        run_ff <= (DELAY_PIN_TXD != last_ff) ? 16'h1 : run_ff + 16'h1;
        len_ff <= FRAME_BUSY ? len_ff + 32'h1 : 32'h0;
        chr_ff <= FRAME_BUSY ? chr_ff + {7'h0, start_seen} : 8'h0;
        if (!RESET_N)
            gap_ff <= 16'hffff;
        else if (start_seen)
            gap_ff <= 16'h1;
        else if (gap_ff != 16'hffff)
            gap_ff <= gap_ff + 16'h1;
    end
    reset_idle_a: assert property (disable iff (1'b0)
        !RESET_N |=> DELAY_PIN_TXD && !FRAME_BUSY) else $error("not idle");
    idle_high_a: assert property (!FRAME_BUSY |-> DELAY_PIN_TXD)
        else $error("line low while idle");
    take_busy_a: assert property (!FRAME_BUSY && take |=> FRAME_BUSY)
        else $error("request not taken");
    no_take_a: assert property (!FRAME_BUSY && !take |=> !FRAME_BUSY)
        else $error("frame without request");
    start_bit_a: assert property ($rose(FRAME_BUSY) |-> ##[1:6] !DELAY_PIN_TXD)
        else $error("no start bit");
    bit_time_a: assert property ($rose(DELAY_PIN_TXD) |->
        run_ff % BIT_CYC == 0 && run_ff <= 9 * BIT_CYC) else $error("bad low run");
    stop_len_a: assert property (FRAME_BUSY && chr_ff != 8'h0 &&
        $fell(DELAY_PIN_TXD) |-> run_ff >= BIT_CYC) else $error("short stop");
    frame_end_a: assert property ($fell(FRAME_BUSY) |-> chr_ff == 8'h6b &&
        len_ff >= 1070 * BIT_CYC && len_ff < 1070 * BIT_CYC + 600)
        else $error("bad frame length");
    take_c: cover property (!FRAME_BUSY && take);
    refused_c: cover property (FRAME_BUSY && take);
    done_c: cover property ($fell(FRAME_BUSY));
endmodule // tdf_frame_tx_chk
bind tdf_frame_tx tdf_frame_tx_chk #(.BIT_CYC(BIT_CYC)) u_tdf_frame_tx_chk (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .DEBUG_ENABLE(DEBUG_ENABLE),
    .FRAME_REQUEST(FRAME_REQUEST), .DELAY_PIN_TXD(DELAY_PIN_TXD),
    .FRAME_BUSY(FRAME_BUSY));
`default_nettype wire

// File: tdf_host_rx.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// host receiver, samples mid-cell; no parity
// ***
module tdf_host_rx #(
    parameter BIT_CYC = 4
) (
    input wire logic clk,
    input wire logic rxd,
    output logic [7:0] data,
    output logic stop_ok,
    output logic got
);
    initial got = 1'b0;
    always
    begin
        @(negedge rxd);
        repeat (BIT_CYC / 2) @(posedge clk);
        repeat (8)
        begin
            repeat (BIT_CYC) @(posedge clk);
            data = {rxd, data[7:1]};
        end
        repeat (BIT_CYC) @(posedge clk);
        stop_ok = rxd;
        got = 1'b1;
        @(posedge clk);
        got = 1'b0;
    end
endmodule // tdf_host_rx
`default_nettype wire

// File: test_touch_debug_frame_tx.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module test_touch_debug_frame_tx;
    localparam BC = 4;
    logic clk, rst_n, en, req, txd, busy, got, stop_ok;
    logic [159:0] raw, base, diff;
    logic [79:0] cap;
    logic [39:0] snr;
    logic [9:0] st, go, vdd, gnd, pp, hi;
    logic [7:0] dac, fw, rx_data, want;
    logic [1:0] mcap;
    logic [703:0] pool;
    logic [855:0] f;
    logic [7:0] exp_q[$];
    integer seed = 32'h42827bda;
    integer error_cnt = 0;
    integer checks_done = 0;
    integer k, j;
    tdf_frame_tx #(.BIT_CYC(BC)) u_tdf_frame_tx (.SYS_CLK(clk),
        .RESET_N(rst_n), .DEBUG_ENABLE(en), .FRAME_REQUEST(req),
        .INPUT_PARASITIC_CAP(cap), .INPUT_RAW_COUNT(raw),
        .INPUT_BASELINE_COUNT(base), .INPUT_DIFFERENCE_COUNT(diff),
        .INPUT_PAIR_SNR(snr), .SENSE_INPUT_STATUS(st),
        .GENERAL_OUTPUT_STATUS(go), .COMPENSATED_CURRENT_DAC(dac),
        .FIRMWARE_REVISION_BYTE(fw), .SUPPLY_SHORT_MASK(vdd),
        .GROUND_SHORT_MASK(gnd), .PIN_PAIR_SHORT_MASK(pp),
        .HIGH_CAPACITANCE_MASK(hi), .MODULATOR_CAP_CHECK(mcap),
        .DELAY_PIN_TXD(txd), .FRAME_BUSY(busy));
    tdf_host_rx #(.BIT_CYC(BC)) u_tdf_host_rx (.clk(clk), .rxd(txd),
        .data(rx_data), .stop_ok(stop_ok), .got(got));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // 16-bit counts go out input 0 first, high byte first
    function automatic logic [159:0] hl(input logic [159:0] v);
        for (int n = 0; n < 10; n++)
            hl[159 - 16 * n -: 16] = v[16 * n +: 16];
    endfunction
    task scramble;
        begin
            repeat (22) pool = {pool[671:0], $random(seed)};
            {raw, base, diff, cap, snr, fw, dac} = pool[615:0];
            {go, st, hi, pp, gnd, vdd} = pool[675:616];
        end
    endtask
    task step;
        begin
            @(posedge clk);
            #5;
            k++;
        end
    endtask
    task frame(input logic [1:0] m);
        begin
            scramble;
            mcap = m;
            f = {8'h0d, 8'h0a, 8'h80, fw, cap[7:0], cap[15:8], hl(raw),
                cap[23:16], cap[31:24], 8'h0, snr[7:0], 8'h0, snr[15:8],
                6'h0, vdd, 8'h0, 8'h1, 8'h0, 6'h0, st[9:8], 8'h0, st[7:0],
                hl(base), cap[39:32], cap[47:40], cap[55:48], snr[23:16],
                8'h0, snr[31:24], 6'h0, gnd, 8'h0, 8'h2, dac, 6'h0, go[9:8],
                8'h0, go[7:0], hl(diff), cap[63:56], cap[71:64], cap[79:72],
                snr[39:32], 8'h0, 6'h0, mcap, 6'h0, pp, 6'h0, hi,
                8'h0, 8'hff, 8'hff};
            for (j = 0; j < 107; j++)
                exp_q.push_back(f[855 - 8 * j -: 8]);
            req = 1'b1;
            k = 0;
            while (busy !== 1'b1 && k < 10) step;
            `CHK(busy, 1'b1)
            // held request must be ignored, new values must not leak in
            scramble;
            mcap = pool[0] ? 2'h1 : 2'h2;
            // drop it well before the last byte: the sender takes a new
            // request as soon as its last byte is launched
            repeat (50) step;
            req = 1'b0;
            k = 0;
            while (busy !== 1'b0 && k < 6000) step;
            `CHK(busy, 1'b0)
            `CHK(exp_q.size(), 0)
            $display("frame with check code %0d done", m);
        end
    endtask
    always @(posedge got)
    begin
        `CHK(exp_q.size() != 0, 1'b1)
        want = exp_q.pop_front();
        `CHK({stop_ok, rx_data}, {1'b1, want})
    end
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        en = 1'b1;
        req = 1'b0;
        scramble;
        mcap = 2'h0;
        repeat (3) @(posedge clk);
        #5 rst_n = 1'b1;
        for (int m = 0; m < 3; m++)
            frame(m[1:0]);
        step;
        en = 1'b0;
        req = 1'b1;
        repeat (20) step;
        `CHK(busy, 1'b0)
        req = 1'b0;
        $display("disabled request test done");
        repeat (40) step;
        `CHK(exp_q.size(), 0)
        print_verdict;
    end
    initial
    begin
        repeat (25000) @(posedge clk);
        error_cnt++;
        print_verdict;
    end
endmodule // test_touch_debug_frame_tx
`default_nettype wire
